// *** shared/poc_params.svh ***
`ifndef POC_PARAMS_SVH
`define POC_PARAMS_SVH
// timing
`define POC_CLK_HZ      25000000
`define POC_POWER_HZ    60
`define POC_MEM_MS      10'h3E8
`define POC_MS_CLKS     ((`POC_CLK_HZ + 999) / 1000)
`define POC_CYC_CLKS    ((`POC_CLK_HZ + `POC_POWER_HZ - 1) / `POC_POWER_HZ)
// register byte offsets
`define POC_A_CTRL      6'h00
`define POC_A_MINPOL    6'h04
`define POC_A_STATUS    6'h08
`define POC_A_ECFG0     6'h10
`define POC_A_PICK0     6'h20
`define POC_A_DLY0      6'h30
`define POC_A_STRIDE    6'h04
// reset values
`define POC_MTA_RST     9'h01E
`define POC_MINPOL_RST  16'h0033
`define POC_PICK_RST    16'h0064
`define POC_BTT_RST     2'h1
// arithmetic
`define POC_CT_FLOOR    16'h0005
`define POC_V_NOM       16'h0400
`define POC_V_SHIFT     10
`define POC_ANG_90      11'h05A
`define POC_ANG_180     9'h0B4
`define POC_ANG_270     11'h10E
`define POC_ANG_360     11'h168
`define POC_ANG_720     11'h2D0
`define POC_BTT_NONE    2'h0
`endif

// *** shared/poc_pkg.sv ***
package poc_pkg;
	typedef struct packed {
		logic [15:0] mag;
		logic [8:0]  ang;
	} poc_phasor_t;
	typedef enum logic [1:0] {
		POC_DIR_OFF = 2'h0,
		POC_DIR_FWD = 2'h1,
		POC_DIR_REV = 2'h2
	} poc_dir_t;
	typedef struct packed {
		logic [3:0] lmask;
		logic       restr;
		logic       blk;
		poc_dir_t   dir;
	} poc_ecfg_t;
	typedef enum logic [3:0] {
		POC_MEM_CIF  = 4'h1,
		POC_MEM_LIVE = 4'h2,
		POC_MEM_HOLD = 4'h4,
		POC_MEM_EXP  = 4'h8
	} poc_mem_t;
endpackage

// *** hw/poc_phase_oc.sv ***
// Overview of operation
// RULE1: two time, two instant, one directional element
// RULE2: per element direction: off, forward, reverse
// RULE3: element blocked by setting or logic inputs
// RULE4: time elements judge each phase alone
// RULE5: restraint scales pickup by phase voltage
// RULE6: pickup writes ignored during external protection control; code ignores them only for restrained elements 0,1
// RULE7: no bus transformer forces restraint off
// RULE8: restrained pickup never below 0.05 x CT
// RULE9: instant elements per phase, directionally supervised
// RULE10: directional elements wait one power cycle
// RULE11: per phase quadrature polarization only
// RULE12: polarizing voltage chosen by phase sequence
// RULE13: last polarizing voltage above minimum is stored
// RULE14: memory valid one second, then expired
// RULE15: expiry blocks or frees directional elements
// RULE16: memory refreshed when voltage returns
// RULE17: close into fault follows expiry setting
// RULE18: supervision resumes when voltage above minimum
// RULE19: torque angle 0 to 359, default 30
// RULE20: each phase classed forward or reverse
// RULE21: forward within 90 degrees of torque line
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "poc_params.svh"
module poc_phase_oc #(
	parameter int unsigned CYC_CLKS = `POC_CYC_CLKS,
	parameter int unsigned MS_CLKS  = `POC_MS_CLKS
) (
	input  wire logic                        sys_clk_i,         // system clock
	input  wire logic                        rst_b_i,           // sync reset, active low
	input  wire logic [5:0]                  avs_address_i,     // byte address
	input  wire logic                        avs_read_i,        // read request
	input  wire logic                        avs_write_i,       // write request
	input  wire logic [31:0]                 avs_writedata_i,   // write data
	input  wire logic [3:0]                  avs_byteenable_i,  // byte lanes
	output logic      [31:0]                 avs_readdata_o,    // read data
	output logic                             avs_waitrequest_o, // stall
	input  wire poc_pkg::poc_phasor_t [2:0]  cur_i,             // phase currents c,b,a
	input  wire poc_pkg::poc_phasor_t [2:0]  vll_i,             // line voltages ca,bc,ab
	input  wire logic [2:0][15:0]            vph_mag_i,         // phase voltage magnitudes
	input  wire logic [3:0]                  logic_in_i,        // blocking logic inputs
	input  wire logic                        prot_ctrl_i,       // manual close/cold load/reclose active
	output logic      [11:0]                 operate_o,         // element*3+phase operate
	output logic      [2:0]                  forward_o,         // direction per phase
	output logic      [2:0]                  mem_expired_o      // memory expired per phase
);
	localparam logic [19:0] CYC_L = 20'(CYC_CLKS);
	localparam logic [14:0] MS_L  = 15'(MS_CLKS);

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// forward when current lies within 90 degrees of the torque line
	function automatic logic dir_fwd(input logic [8:0] ia, input logic [8:0] pa, input logic [8:0] max_torque_angle);
		logic [10:0] s;
		logic [10:0] d;
		s = {2'h0, ia} + `POC_ANG_720 - {2'h0, pa} - {2'h0, max_torque_angle};
		d = 11'(s % `POC_ANG_360);
		return (d <= `POC_ANG_90) || (d >= `POC_ANG_270); // RULE21 RULE11
	endfunction

	function automatic logic [8:0] rot180(input logic [8:0] a);
		return (a >= `POC_ANG_180) ? 9'(a - `POC_ANG_180) : 9'(a + `POC_ANG_180);
	endfunction

	function automatic logic [15:0] restrain(input logic [15:0] p, input logic [15:0] v);
		logic [15:0] vr;
		logic [31:0] pr;
		logic [15:0] q;
		vr = (v > `POC_V_NOM) ? `POC_V_NOM : v;
		pr = p * vr; // RULE5
		q  = pr[`POC_V_SHIFT +: 16];
		return (q < `POC_CT_FLOOR) ? `POC_CT_FLOOR : q; // RULE8
	endfunction

	// settings
	logic                   acb_ff;
	logic                   boe_ff;
	logic [1:0]             btt_ff;
	logic [8:0]             mta_ff;
	logic [15:0]            minpol_ff;
	poc_pkg::poc_ecfg_t     ecfg_ff [4];
	logic [15:0]            pick_ff [4];
	logic [15:0]            dly_ff  [2];
	// bus
	logic                   wait_ff;
	logic [31:0]            rdata_ff;
	logic                   wr;
	// timing
	logic [19:0]            cyc_cnt_ff;
	logic                   cyc_tick_ff;
	logic [14:0]            ms_cnt_ff;
	logic                   ms_tick_ff;
	// voltage memory
	poc_pkg::poc_mem_t      mem_ff    [3];
	logic [9:0]             mem_tmr_ff[3];
	logic [8:0]             mem_ang_ff[3];
	poc_pkg::poc_phasor_t   pol       [3];
	logic [2:0]             live;
	logic [2:0]             valid;
	logic [2:0]             fwd;
	// elements
	logic [19:0]            dcnt_ff [12];
	logic [15:0]            tcnt_ff [6];
	logic [11:0]            cond;
	logic [11:0]            dirctl;
	logic [11:0]            nxt_op;
	logic [11:0]            op_ff;
	logic [2:0]             fwd_ff;

	assign wr = avs_write_i && !wait_ff;

	// one-cycle answer: waitrequest drops the cycle after a request is seen
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wait_ff <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && wait_ff) begin
			wait_ff <= 1'b0;
		end else begin
			wait_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			acb_ff    <= 1'b0;
			boe_ff    <= 1'b0;
			btt_ff    <= `POC_BTT_RST;
			mta_ff    <= `POC_MTA_RST; // RULE19
			minpol_ff <= `POC_MINPOL_RST;
		end else if (wr && avs_address_i == `POC_A_CTRL) begin
			{mta_ff, btt_ff, boe_ff, acb_ff} <= 13'(merge({19'h0, mta_ff, btt_ff, boe_ff, acb_ff},
				avs_writedata_i, avs_byteenable_i));
		end else if (wr && avs_address_i == `POC_A_MINPOL) begin
			minpol_ff <= 16'(merge({16'h0, minpol_ff}, avs_writedata_i, avs_byteenable_i));
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int e = 0; e < 4; e++) begin
				ecfg_ff[e] <= '0;
				pick_ff[e] <= `POC_PICK_RST;
			end
			dly_ff[0] <= 16'h0000;
			dly_ff[1] <= 16'h0000;
		end else if (wr) begin
			for (int e = 0; e < 4; e++) begin
				if (avs_address_i == 6'(`POC_A_ECFG0 + `POC_A_STRIDE * e)) begin
					ecfg_ff[e] <= 8'(merge({24'h0, ecfg_ff[e]}, avs_writedata_i, avs_byteenable_i)); // RULE2 RULE3
				end
				// restrained pickup is frozen while other functions steer the protection
				if (avs_address_i == 6'(`POC_A_PICK0 + `POC_A_STRIDE * e) &&
					!(e < 2 && ecfg_ff[e].restr && prot_ctrl_i)) begin // RULE6
					pick_ff[e] <= 16'(merge({16'h0, pick_ff[e]}, avs_writedata_i, avs_byteenable_i));
				end
			end
			for (int e = 0; e < 2; e++) begin
				if (avs_address_i == 6'(`POC_A_DLY0 + `POC_A_STRIDE * e)) begin
					dly_ff[e] <= 16'(merge({16'h0, dly_ff[e]}, avs_writedata_i, avs_byteenable_i));
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_i && wait_ff) begin
			rdata_ff <= 32'h0000_0000;
			case (avs_address_i)
				`POC_A_CTRL:   rdata_ff <= {19'h0, mta_ff, btt_ff, boe_ff, acb_ff};
				`POC_A_MINPOL: rdata_ff <= {16'h0, minpol_ff};
				`POC_A_STATUS: begin
					for (int p = 0; p < 3; p++) begin
						rdata_ff[21+p] <= mem_ff[p] == poc_pkg::POC_MEM_EXP;
						rdata_ff[18+p] <= mem_ff[p] == poc_pkg::POC_MEM_CIF;
					end
					rdata_ff[17:15] <= valid;
					rdata_ff[14:12] <= fwd_ff;
					rdata_ff[11:0]  <= op_ff;
				end
				default: begin
					for (int e = 0; e < 4; e++) begin
						if (avs_address_i == 6'(`POC_A_ECFG0 + `POC_A_STRIDE * e)) begin
							rdata_ff <= {24'h0, ecfg_ff[e]};
						end
						if (avs_address_i == 6'(`POC_A_PICK0 + `POC_A_STRIDE * e)) begin
							rdata_ff <= {16'h0, pick_ff[e]};
						end
					end
					for (int e = 0; e < 2; e++) begin
						if (avs_address_i == 6'(`POC_A_DLY0 + `POC_A_STRIDE * e)) begin
							rdata_ff <= {16'h0, dly_ff[e]};
						end
					end
				end
			endcase
		end
	end

	// power cycle and millisecond enables
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cyc_cnt_ff  <= 20'h00000;
			cyc_tick_ff <= 1'b0;
			ms_cnt_ff   <= 15'h0000;
			ms_tick_ff  <= 1'b0;
		end else begin
			cyc_tick_ff <= cyc_cnt_ff == CYC_L - 20'h00001;
			cyc_cnt_ff  <= (cyc_cnt_ff == CYC_L - 20'h00001) ? 20'h00000 : cyc_cnt_ff + 20'h00001;
			ms_tick_ff  <= ms_cnt_ff == MS_L - 15'h0001;
			ms_cnt_ff   <= (ms_cnt_ff == MS_L - 15'h0001) ? 15'h0000 : ms_cnt_ff + 15'h0001;
		end
	end

	// polarizing selection: a uses bc, b uses ca, c uses ab; reversed for acb
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			pol[p] = vll_i[(p + 1) % 3]; // RULE12 RULE11
			if (acb_ff) begin
				pol[p].ang = rot180(vll_i[(p + 1) % 3].ang); // RULE12
			end
			live[p]  = pol[p].mag > minpol_ff;
			valid[p] = mem_ff[p] == poc_pkg::POC_MEM_LIVE || mem_ff[p] == poc_pkg::POC_MEM_HOLD;
			fwd[p]   = dir_fwd(cur_i[p].ang, mem_ang_ff[p], mta_ff); // RULE20
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int p = 0; p < 3; p++) begin
				mem_ff[p]     <= poc_pkg::POC_MEM_CIF;
				mem_tmr_ff[p] <= 10'h000;
				mem_ang_ff[p] <= 9'h000;
			end
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (live[p]) begin
					mem_ff[p]     <= poc_pkg::POC_MEM_LIVE; // RULE16 RULE18
					mem_ang_ff[p] <= pol[p].ang; // RULE13
					mem_tmr_ff[p] <= 10'h000;
				end else begin
					case (mem_ff[p])
						poc_pkg::POC_MEM_LIVE: mem_ff[p] <= poc_pkg::POC_MEM_HOLD;
						poc_pkg::POC_MEM_HOLD: begin
							if (ms_tick_ff) begin
								mem_tmr_ff[p] <= mem_tmr_ff[p] + 10'h001;
							end
							if (mem_tmr_ff[p] >= `POC_MEM_MS) begin
								mem_ff[p] <= poc_pkg::POC_MEM_EXP; // RULE14
							end
						end
						poc_pkg::POC_MEM_CIF: mem_ff[p] <= poc_pkg::POC_MEM_CIF;
						poc_pkg::POC_MEM_EXP: mem_ff[p] <= poc_pkg::POC_MEM_EXP;
						default: mem_ff[p] <= poc_pkg::POC_MEM_CIF;
					endcase
				end
			end
		end
	end

	// element k = e*3+p; elements 0,1 time graded, 2,3 instantaneous
	always_comb begin
		for (int k = 0; k < 12; k++) begin
			int          e;
			int          p;
			logic [15:0] pu;
			logic        permit;
			logic        blocked;
			permit  = 1'b1;
			blocked = 1'b0;
			e       = k / 3;
			p       = k % 3;
			pu      = pick_ff[e];
			if (e < 2 && ecfg_ff[e].restr && btt_ff != `POC_BTT_NONE) begin // RULE7
				pu = restrain(pick_ff[e], vph_mag_i[p]); // RULE5 RULE4
			end
			dirctl[k] = ecfg_ff[e].dir != poc_pkg::POC_DIR_OFF;
			if (!dirctl[k]) begin
				permit = 1'b1; // RULE2
			end else if (valid[p]) begin
				permit = fwd[p] == (ecfg_ff[e].dir == poc_pkg::POC_DIR_FWD); // RULE2 RULE9
			end else begin
				permit = !boe_ff; // RULE15 RULE17
			end
			blocked   = ecfg_ff[e].blk || |(logic_in_i & ecfg_ff[e].lmask); // RULE3
			cond[k]   = cur_i[p].mag >= pu && permit && !blocked; // RULE4 RULE9
			nxt_op[k] = cond[k] && (!dirctl[k] || dcnt_ff[k] == CYC_L); // RULE10
			if (e < 2) begin
				nxt_op[k] = nxt_op[k] && tcnt_ff[k] >= dly_ff[e];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int k = 0; k < 12; k++) begin
				dcnt_ff[k] <= 20'h00000;
			end
			for (int k = 0; k < 6; k++) begin
				tcnt_ff[k] <= 16'h0000;
			end
		end else begin
			for (int k = 0; k < 12; k++) begin
				if (!cond[k]) begin
					dcnt_ff[k] <= 20'h00000;
				end else if (dirctl[k] && dcnt_ff[k] < CYC_L) begin
					dcnt_ff[k] <= dcnt_ff[k] + 20'h00001; // RULE10
				end
			end
			for (int k = 0; k < 6; k++) begin
				if (!cond[k]) begin
					tcnt_ff[k] <= 16'h0000;
				end else if (cyc_tick_ff && tcnt_ff[k] < dly_ff[k / 3]) begin
					tcnt_ff[k] <= tcnt_ff[k] + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			op_ff  <= 12'h000;
			fwd_ff <= 3'h0;
		end else begin
			op_ff  <= nxt_op; // RULE1 RULE3
			fwd_ff <= fwd & valid; // RULE20
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mem_expired_o <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				mem_expired_o[p] <= mem_ff[p] == poc_pkg::POC_MEM_EXP; // RULE14
			end
		end
	end

	assign operate_o         = op_ff;
	assign forward_o         = fwd_ff;
	assign avs_readdata_o    = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
endmodule

// *** testbench/poc_xfmr_model.sv ***
`timescale 1ns/100ps
module poc_xfmr_model (
	input  wire logic [15:0]           sys_clk_i_unused_w, // unused
	input  wire logic                  sys_clk_i,          // sampling clock
	input  wire logic [15:0]           i_mag_i,            // phase a current magnitude
	input  wire logic [8:0]            i_ang_i,            // phase a current angle
	input  wire logic [15:0]           v_mag_i,            // line voltage magnitude
	input  wire logic [8:0]            v_ang_i,            // vab angle
	input  wire logic [15:0]           vph_i,              // phase voltage magnitude
	output poc_pkg::poc_phasor_t [2:0] cur_o,              // phase currents
	output poc_pkg::poc_phasor_t [2:0] vll_o,              // line voltages
	output logic [2:0][15:0]           vph_mag_o           // phase voltage magnitudes
);
	initial begin
		cur_o = '0;
		vll_o = '0;
		vph_mag_o = '0;
	end
	// abc rotation: vbc lags vab by 120, vca leads it by 120
	always @(posedge sys_clk_i) begin
		cur_o[0] <= {i_mag_i, i_ang_i};
		cur_o[2:1] <= '0;
		for (int k = 0; k < 3; k++) begin
			vll_o[k] <= {v_mag_i, 9'((int'(v_ang_i) + 360 - 120 * k) % 360)};
			vph_mag_o[k] <= vph_i;
		end
	end
endmodule

// *** testbench/poc_phase_oc_properties.sv ***
`timescale 1ns/100ps
module poc_oc_checker #(
	parameter int unsigned CYC_CLKS = 20,
	parameter int unsigned MS_CLKS  = 10
) (
	input wire logic                       sys_clk_i,         // system clock
	input wire logic                       rst_b_i,           // sync reset, active low
	input wire logic [5:0]                 avs_address_i,     // byte address
	input wire logic                       avs_read_i,        // read request
	input wire logic                       avs_write_i,       // write request
	input wire logic [31:0]                avs_readdata_o,    // read data
	input wire logic                       avs_waitrequest_o, // stall
	input wire poc_pkg::poc_phasor_t [2:0] vll_i,             // line voltages
	input wire logic [11:0]                operate_o,         // element operate
	input wire logic [2:0]                 forward_o,         // direction per phase
	input wire logic [2:0]                 mem_expired_o      // memory expired
);
	logic [31:0] zero_cnt_ff;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// cycles the phase a polarizing voltage has been fully absent
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i || vll_i[1].mag != 16'h0000) begin
			zero_cnt_ff <= 32'h0;
		end else if (zero_cnt_ff != 32'hFFFFFFFF) begin
			zero_cnt_ff <= zero_cnt_ff + 32'h1;
		end
	end
	property p_req_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_req_ack: assert property (p_req_ack) else $error("request not answered");
	property p_ack_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");
	property p_idle_wait; !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
	property p_unmap_rd; avs_read_i && avs_waitrequest_o && avs_address_i == 6'h3C |=> avs_readdata_o == 32'h0; endproperty
	a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
	property p_rst_clear; $rose(rst_b_i) |-> operate_o == 12'h0 && forward_o == 3'h0 && avs_waitrequest_o; endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
	property p_fwd_valid; (forward_o & mem_expired_o) == 3'h0; endproperty
	a_fwd_valid: assert property (p_fwd_valid) else $error("forward with expired memory");
	property p_mem_floor; $rose(mem_expired_o[0]) |-> zero_cnt_ff >= 999 * MS_CLKS; endproperty
	a_mem_floor: assert property (p_mem_floor) else $error("memory expired early");
	property p_mem_refresh; vll_i[1].mag == 16'hFFFF |-> ##[1:3] !mem_expired_o[0]; endproperty
	a_mem_refresh: assert property (p_mem_refresh) else $error("memory not refreshed");
	c_op: cover property ($rose(operate_o[9]));
	c_fwd: cover property ($rose(forward_o[0]));
	c_exp: cover property ($rose(mem_expired_o[0]));
endmodule
bind poc_phase_oc poc_oc_checker #(.CYC_CLKS(CYC_CLKS), .MS_CLKS(MS_CLKS)) poc_oc_checker_i (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.vll_i(vll_i), .operate_o(operate_o), .forward_o(forward_o), .mem_expired_o(mem_expired_o)
);

// *** testbench/tb_poc_phase_oc.sv ***
`timescale 1ns/100ps
module tb_poc_phase_oc;
	localparam int CYC = 20;
	localparam int MS = 10;
	logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, wt, pctl = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] lin = 4'h0, tt = 4'hD;
	logic [11:0] op;
	logic [2:0] fwd, mexp;
	poc_pkg::poc_phasor_t [2:0] cur, vll;
	logic [2:0][15:0] vph;
	logic [15:0] imag = 16'h0, vmag = 16'h0, vp = 16'h0400;
	logic [8:0] iang = 9'h000, vang = 9'h000;
	logic [15:0] ti [4] = '{16'h0040, 16'h0040, 16'h0005, 16'h0004};
	logic [15:0] tv [4] = '{16'h0200, 16'h0200, 16'h0000, 16'h0000};
	int miscompares = 0, num_checks = 0, seed = 32'h01E4, m, a, v, s;
	poc_phase_oc #(.CYC_CLKS(CYC), .MS_CLKS(MS)) poc_phase_oc_i (
		.sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
		.cur_i(cur), .vll_i(vll), .vph_mag_i(vph), .logic_in_i(lin), .prot_ctrl_i(pctl),
		.operate_o(op), .forward_o(fwd), .mem_expired_o(mexp));
	poc_xfmr_model poc_xfmr_model_i (.sys_clk_i_unused_w(16'h0), .sys_clk_i(clk), .i_mag_i(imag), .i_ang_i(iang),
		.v_mag_i(vmag), .v_ang_i(vang), .vph_i(vp), .cur_o(cur), .vll_o(vll), .vph_mag_o(vph));
	always #20 clk = ~clk;
	task end_of_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= ad;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wt !== 1'b0) begin
			miscompares++;
			end_of_test;
		end
	endtask
	task src(input logic [15:0] mg, input logic [8:0] an, input logic [15:0] vm, input logic [8:0] va,
		input logic [15:0] p);
		@(posedge clk);
		imag <= mg;
		iang <= an;
		vmag <= vm;
		vang <= va;
		vp <= p;
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	function automatic logic fwd_exp(input int ia, input int pa, input int mt, input int acb);
		int d;
		d = ((ia - pa - 180 * acb - mt) % 360 + 360) % 360;
		return d <= 90 || d >= 270;
	endfunction
	function automatic int eff(input int vv);
		int e;
		e = 100 * (vv > 1024 ? 1024 : vv) / 1024;
		return e < 5 ? 5 : e;
	endfunction
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, 6'h00, 32'h0);
		chk(q, 32'h1E4);
		bus(1'b0, 6'h3C, 32'h0);
		chk(q, 32'h0);
		// no voltage yet: close into fault releases the directional element
		bus(1'b1, 6'h1C, 32'h1);
		src(16'h0200, 9'h000, 16'h0, 9'h000, 16'h0400);
		w(CYC + 10);
		chk(op, 12'h249);
		bus(1'b1, 6'h00, 32'h1E6);
		w(4);
		chk(op, 12'h049);
		bus(1'b1, 6'h10, 32'h4);
		bus(1'b1, 6'h14, 32'h10);
		@(posedge clk) lin <= 4'h1;
		w(3);
		chk(op, 12'h040);
		bus(1'b1, 6'h10, 32'h0);
		bus(1'b1, 6'h14, 32'h0);
		src(16'h0200, 9'h10E, 16'h0200, 9'h000, 16'h0400);
		w(8);
		chk(op, 12'h049);
		chk(fwd[0], 1'b1);
		w(CYC + 6);
		chk(op, 12'h249);
		src(16'h0200, 9'h05A, 16'h0200, 9'h000, 16'h0400);
		w(4);
		chk(op, 12'h049);
		chk(fwd[0], 1'b0);
		bus(1'b1, 6'h1C, 32'h2);
		w(CYC + 6);
		chk(op, 12'h249);
		for (int k = 0; k < 8; k++) begin
			m = ($random(seed) & 32'h7FFFFFFF) % 360;
			a = ($random(seed) & 32'h7FFFFFFF) % 360;
			v = ($random(seed) & 32'h7FFFFFFF) % 360;
			s = $random(seed) & 1;
			bus(1'b1, 6'h00, {19'h0, m[8:0], 2'h1, 1'b0, s[0]});
			src(16'h0010, a[8:0], 16'h0200, v[8:0], 16'h0400);
			w(6);
			chk(fwd[0], fwd_exp(a, v + 240, m, s));
		end
		bus(1'b1, 6'h00, 32'h1E4);
		bus(1'b1, 6'h1C, 32'h1);
		src(16'h0200, 9'h05A, 16'h0200, 9'h000, 16'h0400);
		w(CYC + 6);
		src(16'h0200, 9'h05A, 16'h0, 9'h000, 16'h0400);
		w(MS * 980);
		chk(mexp, 3'h0);
		chk(op, 12'h049);
		w(MS * 30 + CYC + 6);
		chk(mexp, 3'h7);
		chk(op, 12'h249);
		src(16'h0200, 9'h05A, 16'hFFFF, 9'h000, 16'h0400);
		w(5);
		chk(mexp, 3'h0);
		chk(op, 12'h049);
		bus(1'b1, 6'h10, 32'h8);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 6'h00, {19'h0, 9'h01E, 1'b0, tt[k], 2'h0});
			src(ti[k], 9'h05A, 16'h0200, 9'h000, tv[k]);
			w(4);
			chk(op, {11'h0, tt[k] ? ti[k] >= eff(tv[k]) : ti[k] >= 16'h0064});
		end
		@(posedge clk) pctl <= 1'b1;
		bus(1'b1, 6'h20, 32'h10);
		bus(1'b0, 6'h20, 32'h0);
		chk(q, 32'h64);
		@(posedge clk) pctl <= 1'b0;
		bus(1'b1, 6'h20, 32'h10);
		bus(1'b0, 6'h20, 32'h0);
		chk(q, 32'h10);
		end_of_test;
	end
endmodule
